//--- core/acs_device.sv
// Purpose: converter side: clock source, acquisition, conversion, channels
// Assumes: link pins asynchronous to core_clk_i, synchronised here
// Notes:   16-bit command frame msb first, latched on sclk rise, cs_n low
`timescale 1ns/1ps
`include "acs_params.svh"
// Summary of operation
// - oscillator runs only converting unless auto modes
// - acquisition lasts at least three conversion clocks
// - conversion takes eighteen conversion clocks
// - conversion clock source is programmable
// - serial clock rise toggles conversion clock
// - serial-clock conversion takes thirty-six serial periods
// - host keeps serial period at most one microsecond
// - mode bit zero gives manual channel selection
// - command word channel routed to the sampler
// - automatic scanning is reset default, bit one
// - scan starts from last completed channel
// - scan steps upward then returns to start
// - scan starting at top repeats top channel
// - mux moves to next channel just after acquisition starts
// - sequencing stops when mode bit clears
// - inputs held disconnected during conversion
// - strobe falling edge switches sample to hold
// - auto trigger starts three clocks after end
// - host spaces strobes at least twenty-one clocks
module acs_device
  import acs_pkg::*;
#(
  parameter bit EIGHT_INPUTS = 1'b1
) (
  // clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  // link
  acs_link_if.dev                 link,
  // user side
  output logic                    conversion_clock_o,
  output acs_pkg::acs_chan_type   mux_sel_o,
  output logic                    hold_o,
  output logic                    busy_o,
  output logic                    done_o,
  output acs_pkg::acs_chan_type   last_chan_o,
  output acs_pkg::acs_cfg_type    config_word_o
);
  import acs_pkg::*;

  typedef enum logic [1:0] {ACS_IDLE, ACS_ACQ, ACS_CONV} acs_state_type;

  logic [1:0]    sclk_s_r, stb_s_r, sdi_s_r, cs_s_r;
  logic          sclk_d_r, stb_d_r, cs_d_r;
  logic          sclk_rise, stb_fall, cs_rise;
  logic [15:0]   shift_r;
  logic [4:0]    bit_cnt_r;
  acs_cfg_type   cfg_r;
  logic          chsel_mode, trig_manual, clk_src_sclk, autonap;
  logic [3:0]    osc_cnt_r;
  logic          osc_run;
  logic          osc_tick, conversion_clock_r, conversion_clock_tick;
  acs_state_type state_r;
  logic [4:0]    cnt_r;
  acs_chan_type  chan_r, last_r, scan_start_r, high_ch;
  logic          scanning_r, cmd_chsel_r;
  acs_chan_type  cmd_ch_r;
  logic          done_r;

  assign chsel_mode   = cfg_r[`ACS_CHSEL_MODE_BIT];
  assign trig_manual  = cfg_r[`ACS_TRIG_MODE_BIT];
  assign clk_src_sclk = cfg_r[`ACS_CLK_SRC_BIT];
  assign autonap      = cfg_r[`ACS_AUTONAP_BIT];
  assign high_ch      = EIGHT_INPUTS ? `ACS_HIGH_CH_8IN : `ACS_HIGH_CH_4IN;

  // two-flop synchronisers, second stage only is read
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_s_r <= 2'h0;
      stb_s_r  <= 2'h3;
      sdi_s_r  <= 2'h0;
      cs_s_r   <= 2'h3;
    end else begin
      sclk_s_r <= {sclk_s_r[0], link.sclk};
      stb_s_r  <= {stb_s_r[0], link.convert_strobe_n};
      sdi_s_r  <= {sdi_s_r[0], link.sdi};
      cs_s_r   <= {cs_s_r[0], link.cs_n};
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_d_r <= 1'b0;
      stb_d_r  <= 1'b1;
      cs_d_r   <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s_r[1];
      stb_d_r  <= stb_s_r[1];
      cs_d_r   <= cs_s_r[1];
    end
  end

  assign sclk_rise = sclk_s_r[1] & ~sclk_d_r;
  assign stb_fall  = ~stb_s_r[1] & stb_d_r;
  assign cs_rise   = cs_s_r[1] & ~cs_d_r;

  // command word shift in
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_r   <= 16'h0000;
      bit_cnt_r <= 5'h00;
    end else if (cs_s_r[1]) begin
      bit_cnt_r <= 5'h00;
    end else if (sclk_rise) begin
      shift_r   <= {shift_r[14:0], sdi_s_r[1]};
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  // config and channel commands decoded at frame end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_r       <= `ACS_CFG_RESET;
      cmd_chsel_r <= 1'b0;
      cmd_ch_r    <= `ACS_RESET_CH;
    end else begin
      cmd_chsel_r <= 1'b0;
      if (cs_rise && bit_cnt_r >= `ACS_CMD_BITS) begin
        if (shift_r[15:12] == `ACS_CFG_WRITE)
          cfg_r <= shift_r[11:0];
        else if (shift_r[15] == `ACS_CMD_OP_CHSEL) begin
          cmd_chsel_r <= 1'b1;
          // four-input parts ignore the lowest channel bit
          cmd_ch_r    <= EIGHT_INPUTS ?
                         shift_r[`ACS_CMD_CH_MSB:`ACS_CMD_CH_LSB] :
                         {1'b0, shift_r[`ACS_CMD_CH_MSB:`ACS_CMD_CH_LSB+1]};
        end
      end
    end
  end

  // internal oscillator stand-in, gated outside conversion only in manual trigger with autonap clear
  assign osc_run = (state_r == ACS_CONV) || !trig_manual || autonap;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i)
      osc_cnt_r <= 4'h0;
    else if (!osc_run || osc_cnt_r == `ACS_OSC_DIV - 4'h1)
      osc_cnt_r <= 4'h0;
    else
      osc_cnt_r <= osc_cnt_r + 4'h1;
  end
  assign osc_tick = osc_run && osc_cnt_r == `ACS_OSC_DIV - 4'h1;

  // conversion clock: toggle per source tick, count on its rise
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i)
      conversion_clock_r <= 1'b0;
    else if (clk_src_sclk ? sclk_rise : osc_tick)
      conversion_clock_r <= ~conversion_clock_r;
  end
  assign conversion_clock_tick = (clk_src_sclk ? sclk_rise : osc_tick) & ~conversion_clock_r;

  // acquisition / conversion sequencer
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ACS_IDLE;
      cnt_r   <= 5'h00;
      done_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        ACS_IDLE: begin
          state_r <= ACS_ACQ;
          cnt_r   <= 5'h00;
        end
        ACS_ACQ: begin
          // count restarts while manual, so an auto start waits full acq
          if (trig_manual)
            cnt_r <= 5'h00;
          else if (conversion_clock_tick && cnt_r < `ACS_ACQ_CCLKS)
            cnt_r <= cnt_r + 5'h01;
          if (trig_manual && stb_fall) begin
            state_r <= ACS_CONV;
            cnt_r   <= 5'h00;
          end else if (!trig_manual && cnt_r >= `ACS_ACQ_CCLKS) begin
            state_r <= ACS_CONV;
            cnt_r   <= 5'h00;
          end
        end
        ACS_CONV: begin
          if (conversion_clock_tick) begin
            if (cnt_r == `ACS_CONV_CCLKS - 5'h01) begin
              state_r <= ACS_ACQ;
              cnt_r   <= 5'h00;
              done_r  <= 1'b1;
            end else
              cnt_r <= cnt_r + 5'h01;
          end
        end
        default: begin
          state_r <= ACS_IDLE;
          cnt_r   <= 5'h00;
        end
      endcase
    end
  end

  // channel control: manual commands and automatic scan
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chan_r       <= `ACS_RESET_CH;
      last_r       <= `ACS_RESET_CH;
      scan_start_r <= `ACS_RESET_CH;
      scanning_r   <= 1'b0;
    end else begin
      if (done_r)
        last_r <= chan_r;
      if (!chsel_mode) begin
        scanning_r <= 1'b0;
        if (cmd_chsel_r && state_r != ACS_CONV)
          chan_r <= cmd_ch_r;
      end else if (!scanning_r && state_r != ACS_CONV) begin
        scanning_r   <= 1'b1;
        chan_r       <= last_r;
        scan_start_r <= last_r;
      end else if (scanning_r && done_r) begin
        if (chan_r >= high_ch)
          chan_r <= scan_start_r;
        else
          chan_r <= chan_r + 3'h1;
      end
    end
  end

  // registered outputs
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      conversion_clock_o <= 1'b0;
      mux_sel_o          <= `ACS_RESET_CH;
      hold_o             <= 1'b0;
      busy_o             <= 1'b0;
      done_o             <= 1'b0;
      last_chan_o        <= `ACS_RESET_CH;
      config_word_o      <= `ACS_CFG_RESET;
    end else begin
      conversion_clock_o <= conversion_clock_r;
      mux_sel_o          <= chan_r;
      hold_o             <= (state_r == ACS_CONV);
      busy_o             <= (state_r == ACS_CONV);
      done_o             <= done_r;
      last_chan_o        <= last_r;
      config_word_o      <= cfg_r;
    end
  end
endmodule

//--- core/acs_params.svh
// Purpose: constants for the conversion sequencer ends
// Assumes: 200 MHz core clock
// Notes:   counts are in conversion-clock cycles unless stated
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH
`define ACS_ACQ_CCLKS      5'h03
`define ACS_CONV_CCLKS     5'h12
`define ACS_SPACING_CCLKS  5'h15
`define ACS_CLK_NS         5
`define ACS_STROBE_LOW_NS  40
`define ACS_STROBE_LOW_CYC ((`ACS_STROBE_LOW_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_OSC_DIV        4'h8
`define ACS_LINK_DIV       4'h8
`define ACS_CMD_BITS       5'h10
`define ACS_CMD_CH_MSB     14
`define ACS_CMD_CH_LSB     12
`define ACS_CMD_OP_CHSEL   1'b0
`define ACS_CFG_WRITE      4'he
`define ACS_HIGH_CH_4IN    3'h3
`define ACS_HIGH_CH_8IN    3'h7
`define ACS_RESET_CH       3'h0
`define ACS_CHSEL_MODE_BIT 11
`define ACS_TRIG_MODE_BIT  9
`define ACS_CLK_SRC_BIT    10
`define ACS_AUTONAP_BIT    4
`define ACS_CFG_RESET      12'h8ff
`endif

//--- core/acs_pkg.sv
// Purpose: shared types for the conversion sequencer ends
// Assumes: nothing
// Notes:   constants live in acs_params.svh
package acs_pkg;
  typedef logic [2:0]  acs_chan_type;
  typedef logic [11:0] acs_cfg_type;
  typedef logic [15:0] acs_word_type;
endpackage

//--- core/acs_link_if.sv
// Purpose: pins between host controller and converter sequencer
// Assumes: host makes the serial clock and convert strobe
// Notes:   all pins one-way, so no enables are needed
`timescale 1ns/1ps
interface acs_link_if;
  logic sclk;
  logic convert_strobe_n;
  logic sdi;
  logic cs_n;
  modport dev  (input sclk, input convert_strobe_n, input sdi, input cs_n);
  modport host (output sclk, output convert_strobe_n, output sdi,
                output cs_n);
endinterface

//--- core/acs_host.sv
// Purpose: host controller end: serial clock, strobe, command words
// Assumes: user requests are single-cycle pulses on core_clk_i
// Notes:   serial clock made by divider, runs free after reset
`timescale 1ns/1ps
`include "acs_params.svh"
module acs_host
  import acs_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // link
  acs_link_if.host               link,
  // user side
  input  wire logic              send_i,
  input  acs_pkg::acs_word_type  word_i,
  input  wire logic              convert_i,
  output logic                   ready_o
);
  import acs_pkg::*;

  typedef enum logic [1:0] {ACH_IDLE, ACH_SEND, ACH_END} ach_state_type;

  logic [3:0]    div_r;
  logic          sclk_r, rise_tick, fall_tick;
  ach_state_type state_r;
  acs_word_type  sh_r;
  logic [4:0]    bits_r;
  logic          cs_n_r, sdi_r, stb_n_r;
  logic [3:0]    stb_cnt_r;
  logic [6:0]    space_r;

  // sclk period 2*ACS_LINK_DIV core cycles, well under one microsecond
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_r  <= 4'h0;
      sclk_r <= 1'b0;
    end else if (div_r == `ACS_LINK_DIV - 4'h1) begin
      div_r  <= 4'h0;
      sclk_r <= ~sclk_r;
    end else
      div_r <= div_r + 4'h1;
  end
  assign rise_tick = (div_r == `ACS_LINK_DIV - 4'h1) & ~sclk_r;
  assign fall_tick = (div_r == `ACS_LINK_DIV - 4'h1) & sclk_r;

  // command frame: data changes on sclk fall
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ACH_IDLE;
      sh_r    <= 16'h0000;
      bits_r  <= 5'h00;
      cs_n_r  <= 1'b1;
      sdi_r   <= 1'b0;
    end else begin
      case (state_r)
        ACH_IDLE: if (send_i) begin
          sh_r    <= word_i;
          bits_r  <= 5'h00;
          state_r <= ACH_SEND;
        end
        ACH_SEND: if (fall_tick) begin
          if (bits_r == `ACS_CMD_BITS) begin
            state_r <= ACH_END;
          end else begin
            cs_n_r <= 1'b0;
            sdi_r  <= sh_r[15];
            sh_r   <= {sh_r[14:0], 1'b0};
            bits_r <= bits_r + 5'h01;
          end
        end
        ACH_END: if (rise_tick) begin
          cs_n_r  <= 1'b1;
          state_r <= ACH_IDLE;
        end
        default: state_r <= ACH_IDLE;
      endcase
    end
  end

  // convert strobe low for the least pulse width, then spacing guard
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stb_n_r   <= 1'b1;
      stb_cnt_r <= 4'h0;
      space_r   <= 7'h00;
    end else begin
      if (space_r != 7'h00 && rise_tick)
        space_r <= space_r - 7'h01;
      if (!stb_n_r) begin
        if (stb_cnt_r == 4'(`ACS_STROBE_LOW_CYC))
          stb_n_r <= 1'b1;
        else
          stb_cnt_r <= stb_cnt_r + 4'h1;
      end else if (convert_i && space_r == 7'h00) begin
        stb_n_r   <= 1'b0;
        stb_cnt_r <= 4'h1;
        space_r   <= {1'b0, `ACS_SPACING_CCLKS, 1'b0};
      end
    end
  end

  // sclk never stops, so a conversion on it always completes
  assign link.sclk             = sclk_r;
  assign link.cs_n             = cs_n_r;
  assign link.sdi              = sdi_r;
  assign link.convert_strobe_n = stb_n_r;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i)
      ready_o <= 1'b0;
    else
      ready_o <= (state_r == ACH_IDLE) && !send_i;
  end
endmodule

//--- dv/acs_link_sva.sv
// Purpose: link checks between host and converter ends
// Assumes: link signals are registered in the core clock domain
// Notes:   helper counters measure strobe spacing and frame length
`timescale 1ns/1ps
module acs_link_sva (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // link
  input  wire logic sclk,
  input  wire logic convert_strobe_n,
  input  wire logic sdi,
  input  wire logic cs_n
);
  logic       sclk_r;
  logic [5:0] gap_r;
  logic [4:0] bits_r;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i)
      sclk_r <= 1'b0;
    else
      sclk_r <= sclk;
  end

  // sclk rises since the strobe went back high, saturating
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i)
      gap_r <= 6'h3f;
    else if (!convert_strobe_n)
      gap_r <= 6'h00;
    else if (sclk && !sclk_r && gap_r != 6'h3f)
      gap_r <= gap_r + 6'h01;
  end

  // sclk rises inside the current frame
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i)
      bits_r <= 5'h00;
    else if (cs_n)
      bits_r <= 5'h00;
    else if (sclk && !sclk_r)
      bits_r <= bits_r + 5'h01;
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence strobe_low_s;
    !convert_strobe_n [*8];
  endsequence
  sequence sclk_high_s;
    sclk [*8] ##1 !sclk;
  endsequence

  chk_strobe_min_low: assert property (
    $fell(convert_strobe_n) |-> strobe_low_s)
    else $error("strobe pulse too short");
  chk_strobe_released: assert property (
    $fell(convert_strobe_n) |-> ##[8:20] convert_strobe_n)
    else $error("strobe not released");
  chk_sclk_half_len: assert property (
    $rose(sclk) |-> sclk_high_s)
    else $error("sclk high time wrong");
  chk_sclk_period_max: assert property (
    $rose(sclk) |-> ##[1:200] $rose(sclk))
    else $error("sclk period too long");
  // one rise may fall inside the low pulse itself
  chk_strobe_spacing: assert property (
    $fell(convert_strobe_n) |-> gap_r >= 6'd41)
    else $error("strobes too close");
  chk_frame_bit_count: assert property (
    $rose(cs_n) |-> bits_r inside {5'd16, 5'd17})
    else $error("frame length wrong");
  chk_sdi_stable_high: assert property (
    sclk && $past(sclk) |-> $stable(sdi))
    else $error("sdi moved while sclk high");
  chk_cs_fall_low: assert property (
    $fell(cs_n) |-> !sclk)
    else $error("frame opened with sclk high");
endmodule

//--- dv/adc_conversion_sequencer_tb_top.sv
// Purpose: drives the host user side and watches the converter end
// Assumes: 200 MHz core clock, eight-input converter
// Notes:   config words keep the power-saving bit clear
`timescale 1ns/1ps
`include "acs_params.svh"
module adc_conversion_sequencer_tb_top;
  import acs_pkg::*;
  logic         core_clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         send_i = 1'b0;
  acs_word_type word_i = 16'h0000;
  logic         convert_i = 1'b0;
  logic         ready_o, conversion_clock, hold, busy, done;
  acs_chan_type mux, last_ch;
  acs_cfg_type  cfg;
  int           err_total = 0;
  int           n_checks = 0;

  always #2.5 core_clk_i = ~core_clk_i;

  acs_link_if link ();
  acs_host u_acs_host (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .link(link), .send_i(send_i), .word_i(word_i),
    .convert_i(convert_i), .ready_o(ready_o));
  acs_device #(.EIGHT_INPUTS(1'b1)) u_acs_device (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .link(link),
    .conversion_clock_o(conversion_clock), .mux_sel_o(mux), .hold_o(hold),
    .busy_o(busy), .done_o(done), .last_chan_o(last_ch),
    .config_word_o(cfg));
  acs_link_sva u_acs_link_sva (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .sclk(link.sclk), .convert_strobe_n(link.convert_strobe_n),
    .sdi(link.sdi), .cs_n(link.cs_n));

  task automatic end_of_test();
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic send(input acs_word_type w);
    int i;
    for (i = 0; i < 99 && ready_o !== 1'b1; i++) tick();
    @(posedge core_clk_i);
    send_i <= 1'b1;
    word_i <= w;
    @(posedge core_clk_i);
    send_i <= 1'b0;
    for (i = 0; i < 99 && link.cs_n !== 1'b0; i++) tick();
    for (i = 0; i < 999 && link.cs_n !== 1'b1; i++) tick();
    // let the word cross the synchroniser before looking at busy
    repeat (8) tick();
    for (i = 0; i < 4000 && busy !== 1'b0; i++) tick();
    chk("send_end", 16'h0003, {14'h0, link.cs_n === 1'b1, busy === 1'b0});
    repeat (16) tick();
  endtask

  // waits one conversion: conversion_clock rises before and during it, sclk rises
  task automatic conv(input bit go, output int pre, output int rc,
                      output int rs, output int brk,
                      output acs_chan_type ch);
    int i;
    logic c_q, s_q;
    if (go) begin
      @(posedge core_clk_i);
      convert_i <= 1'b1;
      @(posedge core_clk_i);
      convert_i <= 1'b0;
    end
    {pre, rc, rs, brk} = '0;
    c_q = conversion_clock;
    for (i = 0; i < 4000 && hold !== 1'b1; i++) begin
      tick();
      pre += int'(conversion_clock && !c_q);
      c_q = conversion_clock;
    end
    chk("hold_seen", 16'h0001, {15'h0, hold === 1'b1});
    ch = mux;
    s_q = link.sclk;
    for (i = 0; i < 4000 && done !== 1'b1; i++) begin
      tick();
      rc += int'(conversion_clock && !c_q);
      rs += int'(link.sclk && !s_q);
      brk += int'(done !== 1'b1 && hold !== 1'b1);
      c_q = conversion_clock;
      s_q = link.sclk;
    end
    chk("done_seen", 16'h0001, {15'h0, done === 1'b1});
  endtask

  task automatic scan(input acs_chan_type st);
    int k, p, r, s, b;
    acs_chan_type ch, ex;
    send(16'he8ef);
    ex = st;
    for (k = 0; k < 4; k++) begin
      conv(1'b0, p, r, s, b, ch);
      chk("scan_chan", {13'h0, ex}, {13'h0, ch});
      if (k > 0)
        chk("auto_gap", 16'd3, p[15:0]);
      chk("auto_len", 16'd18, r[15:0]);
      ex = (ex == `ACS_HIGH_CH_8IN) ? st : ex + 3'h1;
      tick();
      chk("next_mux", {13'h0, ex}, {13'h0, mux});
    end
    send(16'he2ef);
  endtask

  initial begin
    int k, p, r, s, b, n;
    acs_chan_type ch, m0;
    logic         c0;
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (2) tick();
    chk("cfg_reset", {4'h0, `ACS_CFG_RESET}, {4'h0, cfg});
    chk("chan_reset", 16'h0000, {13'h0, last_ch});
    for (k = 0; k < 2; k++) begin
      send(k ? 16'he6ef : 16'he2ef);
      chk("cfg", k ? 16'h06ef : 16'h02ef, {4'h0, cfg});
      send({1'b0, 3'h5 + k[2:0], 12'h000});
      chk("mux", 16'h5 + k[15:0], {13'h0, mux});
      conv(1'b1, p, r, s, b, ch);
      chk("conv_len", 16'd18, r[15:0]);
      chk("held", 16'h0, b[15:0]);
      if (k == 1)
        chk("sclk_36", 16'h1, {15'h0, s >= 35 && s <= 37});
      tick();
      chk("last", 16'h5 + k[15:0], {13'h0, last_ch});
      n = 0;
      c0 = conversion_clock;
      repeat (100) begin
        tick();
        n += int'(conversion_clock !== c0);
      end
      if (k == 0)
        chk("osc_idle", 16'h0, n[15:0]);
    end
    scan(3'h6);
    n = 0;
    m0 = mux;
    repeat (400) begin
      tick();
      n += int'(done === 1'b1);
    end
    chk("scan_stop", 16'h0, n[15:0]);
    chk("mux_hold", {13'h0, m0}, {13'h0, mux});
    send(16'he0ef);
    n = 0;
    repeat (400) begin
      tick();
      n += int'(done === 1'b1);
    end
    chk("single_conv", 16'h1, {15'h0, n > 0});
    chk("single_mux", {13'h0, m0}, {13'h0, mux});
    send(16'he2ef);
    send({1'b0, `ACS_HIGH_CH_8IN, 12'h000});
    conv(1'b1, p, r, s, b, ch);
    chk("top_chan", 16'h7, {13'h0, ch});
    scan(`ACS_HIGH_CH_8IN);
    end_of_test();
  end

  initial begin
    #300000;
    err_total++;
    end_of_test();
  end
endmodule
